// File: include/eps_pkg.sv
package eps_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned STARTUP_MS = 50;
  localparam int unsigned TRIAL_MS = 500;
  localparam int unsigned STALE_US = 1000;
  localparam int unsigned BAUD = 115_200;
  localparam int unsigned STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned TRIAL_CYC = TRIAL_MS * (CLK_HZ / 1000);
  localparam int unsigned STALE_CYC = STALE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD;

  localparam int ADR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_POS = 12'h008;
  localparam logic [11:0] OFS_LINK_SEL = 12'h834;
  localparam logic [11:0] OFS_PROTO_SEL = 12'h838;
  localparam logic [11:0] OFS_ADAPTER_MUX_DISABLE = 12'h8B8;
  localparam logic [11:0] OFS_SHARED = 12'h8F0;
  localparam logic [11:0] OFS_DATA_IN = 12'h8FC;
  localparam logic [11:0] OFS_ENC_CLK = 12'h9A8;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_PR_LSB = 4;
  localparam int STAT_LOCK_BIT = 6;
  localparam int STAT_RUN_BIT = 7;
  localparam int STAT_LOST_BIT = 8;
  localparam int PAD_MODE_W = 3;
  localparam logic [2:0] PAD_MODE_GPIO = 3'h7;
  localparam logic [2:0] PAD_MODE_ENG_OUT = 3'h5;
  localparam logic [2:0] PAD_MODE_ENG_IN = 3'h6;

  localparam logic [1:0] PATH_OPEN = 2'h0;
  localparam logic [1:0] PATH_CH2 = 2'h1;
  localparam int IN_OPEN_BIT = 0;
  localparam int IN_CH2_BIT = 11;
  localparam int OUT_OPEN_CLK_BIT = 1;

  typedef enum logic [1:0] {PR_LINK = 2'h0, PR_OPEN = 2'h1, PR_CLOCK = 2'h2} eps_proto_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CFG = 3'h1, ST_START = 3'h3, ST_WAIT = 3'h2,
    ST_TRIAL = 3'h6, ST_LOCK = 3'h7, ST_NEXT = 3'h5
  } eps_state_t;

  typedef struct packed {
    logic mux_disable;
    logic link_select;
    logic clk_not_open;
    logic pad_func;
    logic pad_gpio_out;
    logic [1:0] path_sel;
  } eps_sel_t;

  function automatic eps_sel_t sel_for(eps_proto_t p);
    eps_sel_t s;
    s.mux_disable = 1'b0;
    s.link_select = (p == PR_LINK);
    s.clk_not_open = (p != PR_OPEN);
    s.pad_func = (p != PR_OPEN);
    s.pad_gpio_out = 1'b0;
    s.path_sel = (p == PR_OPEN) ? PATH_OPEN : PATH_CH2;
    return s;
  endfunction : sel_for

  function automatic eps_proto_t next_proto(eps_proto_t p);
    case (p)
      PR_LINK: return PR_OPEN;
      PR_OPEN: return PR_CLOCK;
      default: return PR_LINK;
    endcase
  endfunction : next_proto
endpackage : eps_pkg

// File: hw/eps_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module eps_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // synchronous reset
  input wire logic [W-1:0] d_i, // asynchronous level
  output logic [W-1:0] q_o // synchronised level
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : eps_sync2
`default_nettype wire

// File: hw/eps_uart_tx.sv
`timescale 1ns/100ps
`default_nettype none
module eps_uart_tx #(
  parameter int unsigned DIV = eps_pkg::BAUD_DIV
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // synchronous reset
  input wire logic [7:0] data_i, // byte to send
  input wire logic valid_i, // byte offered
  output logic ready_o, // idle, byte taken when valid
  output logic tx_o // serial line, idle high
);
  import eps_pkg::*;
  logic [15:0] div_r;
  logic [3:0] bit_r;
  logic [9:0] sh_r;

  assign ready_o = (bit_r == 4'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 10'h3FF;
      tx_o <= 1'b1;
    end else begin
      tx_o <= sh_r[0];
      if (ready_o) begin
        if (valid_i) begin
          // start bit, 8 data bits lsb first, stop bit
          sh_r <= {1'b1, data_i, 1'b0};
          bit_r <= 4'hA;
          div_r <= 16'(DIV - 1);
        end
      end else if (div_r == 16'h0000) begin
        sh_r <= {1'b1, sh_r[9:1]};
        bit_r <= bit_r - 4'h1;
        div_r <= 16'(DIV - 1);
      end else begin
        div_r <= div_r - 16'h0001;
      end
    end
  end
endmodule : eps_uart_tx
`default_nettype wire

// File: hw/eps_autoselect.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - configure path, start engine, wait, check position
// - trial timeout moves to next protocol
// - rotate protocols until a valid position
// - stale or invalid position restarts detection
// - send locked position out the console
// - three select outputs choose signal path
// - select levels fixed per protocol
// - shared pad GPIO low for open protocol
// - clock and link share channel two
// - open protocol uses input bit 0
// - selects also pick encoder power supply
module eps_autoselect #(
  parameter int unsigned STARTUP_CYCLES = eps_pkg::STARTUP_CYC,
  parameter int unsigned TRIAL_CYCLES = eps_pkg::TRIAL_CYC,
  parameter int unsigned STALE_CYCLES = eps_pkg::STALE_CYC,
  parameter int unsigned BAUD_DIV = eps_pkg::BAUD_DIV
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [eps_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output eps_pkg::eps_sel_t sel_o, // select pins and pad mode
  output logic engine_run_o, // engine enable, rise starts it
  output eps_pkg::eps_proto_t engine_proto_o, // firmware to run
  input wire logic pos_valid_i, // engine position valid
  input wire logic pos_strobe_i, // new position pulse
  input wire logic [31:0] pos_data_i, // position word
  input wire logic eng_ch2_clk_i, // engine channel two clock
  input wire logic eng_ch2_dout_i, // engine channel two data
  input wire logic eng_ch2_oe_i, // engine channel two drive
  input wire logic [31:0] engine_output_register_i, // engine outputs
  output logic [31:0] engine_input_register_o, // engine inputs
  output logic channel_two_clock_o, // clock pin
  output logic link_data_out_o, // data pin out
  output logic link_drive_enable_o, // data pin enable
  input wire logic link_data_in_i, // data pin in
  input wire logic open_proto_data_in_i, // open sensor data pin
  output logic open_proto_clock_o, // open clock pin
  output logic console_tx_o // serial console
);
  import eps_pkg::*;

  eps_state_t st_r, st_nxt;
  eps_proto_t pr_r, pr_nxt;
  eps_sel_t sel_r;
  logic [31:0] tmr_r, tmr_nxt;
  logic en_r, lost_r, restart_req, lost_set;
  logic [31:0] pos_r;
  logic [PAD_MODE_W+28:PAD_MODE_W] pad_sw_r [6];
  logic [31:0] tx_word_r;
  logic [2:0] tx_left_r;
  logic uart_ready;
  logic link_in_s, open_in_s;

  // wishbone decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land on the edge where the master samples ack, while it still holds the request
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire [11:0] adr = {wb_adr_i[11:2], 2'b00};
  wire hit_ctrl = (adr == OFS_CTRL);
  wire hit_stat = (adr == OFS_STAT);
  wire hit_pos = (adr == OFS_POS);
  wire [2:0] pad_idx = (adr == OFS_LINK_SEL) ? 3'd0 :
                       (adr == OFS_PROTO_SEL) ? 3'd1 :
                       (adr == OFS_ADAPTER_MUX_DISABLE) ? 3'd2 :
                       (adr == OFS_SHARED) ? 3'd3 :
                       (adr == OFS_DATA_IN) ? 3'd4 :
                       (adr == OFS_ENC_CLK) ? 3'd5 : 3'd7;
  wire pad_hit = (pad_idx != 3'd7);
  // pad mode is fixed in logic, the shared pad's set by the sequencer, so software cannot fight it
  wire [2:0] pad_mode = (pad_idx == 3'd3) ? (sel_r.pad_func ? PAD_MODE_ENG_OUT : PAD_MODE_GPIO) :
                        (pad_idx == 3'd4) ? PAD_MODE_ENG_IN :
                        (pad_idx == 3'd5) ? PAD_MODE_ENG_OUT : PAD_MODE_GPIO;
  wire [31:0] be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] stat_word = (32'(st_r) << STAT_ST_LSB) | (32'(pr_r) << STAT_PR_LSB) |
                          (32'(st_r == ST_LOCK) << STAT_LOCK_BIT) |
                          (32'(engine_run_o) << STAT_RUN_BIT) | (32'(lost_r) << STAT_LOST_BIT);
  wire [31:0] rd_word = hit_ctrl ? 32'(en_r) << CTRL_EN_BIT :
                        hit_stat ? stat_word :
                        hit_pos ? pos_r :
                        pad_hit ? {pad_sw_r[pad_idx[2:0]], pad_mode} : 32'h0000_0000;
  wire ctrl_wr = wr & hit_ctrl & wb_sel_i[0];
  wire lost_clr = wr & hit_stat & wb_sel_i[1] & wb_dat_i[STAT_LOST_BIT];
  assign restart_req = ctrl_wr & wb_dat_i[CTRL_RESTART_BIT];
  wire got_pos = pos_valid_i & pos_strobe_i;
  wire tx_load = got_pos & (st_r == ST_TRIAL || st_r == ST_LOCK) & (tx_left_r == 3'd0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      en_r <= CTRL_EN_RST;
      lost_r <= 1'b0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_word : 32'h0000_0000;
      if (ctrl_wr) begin
        en_r <= wb_dat_i[CTRL_EN_BIT];
      end
      // a loss in the same cycle as the clear survives it
      lost_r <= lost_set | (lost_r & ~lost_clr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 6; i++) begin
        pad_sw_r[i] <= '0;
      end
    end else if (wr & pad_hit) begin
      pad_sw_r[pad_idx] <= (pad_sw_r[pad_idx] & ~be_mask[31:3]) | (wb_dat_i[31:3] & be_mask[31:3]);
    end
  end

  // detection sequencer
  always_comb begin
    st_nxt = st_r;
    pr_nxt = pr_r;
    lost_set = 1'b0;
    tmr_nxt = (tmr_r != 32'h0000_0000) ? tmr_r - 32'h0000_0001 : 32'h0000_0000;
    case (st_r)
      ST_IDLE: begin
        st_nxt = ST_CFG;
        pr_nxt = PR_LINK;
      end
      ST_CFG: st_nxt = ST_START;
      ST_START: begin
        st_nxt = ST_WAIT;
        tmr_nxt = 32'(STARTUP_CYCLES - 1);
      end
      ST_WAIT: begin
        if (tmr_r == 32'h0000_0000) begin
          st_nxt = ST_TRIAL;
          tmr_nxt = 32'(TRIAL_CYCLES - 1);
        end
      end
      ST_TRIAL: begin
        if (got_pos) begin
          st_nxt = ST_LOCK;
          tmr_nxt = 32'(STALE_CYCLES - 1);
        end else if (tmr_r == 32'h0000_0000) begin
          st_nxt = ST_NEXT;
        end
      end
      ST_LOCK: begin
        if (!pos_valid_i || tmr_r == 32'h0000_0000) begin
          // retry the locked protocol first, then rotate as usual
          st_nxt = ST_CFG;
          lost_set = 1'b1;
        end else if (got_pos) begin
          tmr_nxt = 32'(STALE_CYCLES - 1);
        end
      end
      ST_NEXT: begin
        st_nxt = ST_CFG;
        pr_nxt = next_proto(pr_r);
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!en_r) begin
      st_nxt = ST_IDLE;
    end else if (restart_req) begin
      st_nxt = ST_CFG;
      pr_nxt = PR_LINK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      pr_r <= PR_LINK;
      tmr_r <= 32'h0000_0000;
      sel_r <= '0;
      engine_run_o <= 1'b0;
      engine_proto_o <= PR_LINK;
      pos_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      pr_r <= pr_nxt;
      tmr_r <= tmr_nxt;
      if (st_r == ST_CFG) begin
        sel_r <= sel_for(pr_r);
      end
      // engine is held off through CFG and START so path settles first
      engine_run_o <= (st_nxt == ST_WAIT) | (st_nxt == ST_TRIAL) | (st_nxt == ST_LOCK);
      engine_proto_o <= pr_r;
      if (got_pos) begin
        pos_r <= pos_data_i;
      end
    end
  end
  assign sel_o = sel_r;

  // pin routing
  eps_sync2 #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link_data_in_i, open_proto_data_in_i}),
    .q_o({link_in_s, open_in_s})
  );
  wire ch2 = (sel_r.path_sel == PATH_CH2);
  wire opn = (sel_r.path_sel == PATH_OPEN);
  wire [31:0] in_word = (32'(ch2 & link_in_s) << IN_CH2_BIT) |
                        (32'(opn & open_in_s) << IN_OPEN_BIT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_two_clock_o <= 1'b0;
      link_data_out_o <= 1'b0;
      link_drive_enable_o <= 1'b0;
      open_proto_clock_o <= 1'b0;
      engine_input_register_o <= 32'h0000_0000;
    end else begin
      channel_two_clock_o <= ch2 & eng_ch2_clk_i;
      link_data_out_o <= ch2 & eng_ch2_dout_i;
      link_drive_enable_o <= ch2 & eng_ch2_oe_i;
      open_proto_clock_o <= opn & engine_output_register_i[OUT_OPEN_CLK_BIT];
      engine_input_register_o <= in_word;
    end
  end

  // console: four bytes msb first; positions arriving before the last byte is handed to the uart are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_word_r <= 32'h0000_0000;
      tx_left_r <= 3'd0;
    end else if (tx_load) begin
      tx_word_r <= pos_data_i;
      tx_left_r <= 3'd4;
    end else if (tx_left_r != 3'd0 && uart_ready) begin
      tx_word_r <= {tx_word_r[23:0], 8'h00};
      tx_left_r <= tx_left_r - 3'd1;
    end
  end

  eps_uart_tx #(.DIV(BAUD_DIV)) u_uart (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .data_i(tx_word_r[31:24]),
    .valid_i(tx_left_r != 3'd0),
    .ready_o(uart_ready),
    .tx_o(console_tx_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_run_after_cfg;
    $rose(engine_run_o) |-> st_r == ST_WAIT && sel_o == sel_for(engine_proto_o);
  endproperty
  a_run_after_cfg: assert property (p_run_after_cfg) else $error("engine started before path");
  property p_timeout_next;
    st_r == ST_TRIAL && tmr_r == 32'h0 && !got_pos && en_r && !restart_req
      |=> st_r == ST_NEXT ##1 (st_r == ST_CFG || !$past(en_r));
  endproperty
  a_timeout_next: assert property (p_timeout_next) else $error("trial timeout missed");
  property p_rotate;
    st_r == ST_NEXT && en_r && !restart_req |=> pr_r == next_proto($past(pr_r));
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotation order wrong");
  property p_lost;
    st_r == ST_LOCK && !pos_valid_i && en_r |=> st_r == ST_CFG && !engine_run_o && lost_r;
  endproperty
  a_lost: assert property (p_lost) else $error("lost position not restarted");
  property p_console;
    tx_load |=> tx_left_r == 3'd4 && tx_word_r == $past(pos_data_i);
  endproperty
  a_console: assert property (p_console) else $error("position not sent");
  property p_sel_table;
    st_r == ST_CFG |=> sel_o == sel_for($past(pr_r));
  endproperty
  a_sel_table: assert property (p_sel_table) else $error("select table wrong");
  property p_levels;
    !sel_o.mux_disable && (!sel_o.link_select || sel_o.clk_not_open);
  endproperty
  a_levels: assert property (p_levels) else $error("select levels wrong");
  property p_pad;
    !sel_o.pad_func |-> !sel_o.pad_gpio_out && sel_o.path_sel == PATH_OPEN && !sel_o.clk_not_open;
  endproperty
  a_pad: assert property (p_pad) else $error("shared pad mode wrong");
  property p_ch2;
    sel_o.path_sel == PATH_CH2 |=> channel_two_clock_o == $past(eng_ch2_clk_i);
  endproperty
  a_ch2: assert property (p_ch2) else $error("channel two not routed");
  property p_open_clk;
    sel_o.path_sel == PATH_OPEN |=> open_proto_clock_o == $past(engine_output_register_i[1]);
  endproperty
  a_open_clk: assert property (p_open_clk) else $error("open clock not routed");

  c_lock: cover property (st_r == ST_TRIAL ##1 st_r == ST_LOCK);
  c_clock_trial: cover property (st_r == ST_CFG && pr_r == PR_CLOCK);
  c_lost: cover property (st_r == ST_LOCK ##1 st_r == ST_CFG);
endmodule : eps_autoselect
`default_nettype wire

// File: testbench/eps_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module eps_far_side (
  input wire logic clk_i, // bench clock, paces the idle pattern
  input wire eps_pkg::eps_sel_t sel_i, // select pins from the device
  input wire logic chan_dout_i, // channel two data pin
  input wire logic chan_en_i, // channel two drive enable
  input wire logic enc_level_i, // level the encoder returns
  output logic link_data_in_o, // channel two data back
  output logic open_proto_data_in_o, // open protocol data back
  output logic mux_output_enable_n_o, // adapter mux enable
  output logic [1:0] led_o, // interface indicator
  output logic [2:0] supply_o // supply on: link, clock, open
);
  import eps_pkg::*;
  logic idle_pat = 1'b0;
  logic wire_lvl;
  logic on;
  always @(posedge clk_i) idle_pat <= ~idle_pat;
  assign mux_output_enable_n_o = sel_i.mux_disable;
  assign on = !mux_output_enable_n_o;
  // a line the mux does not route floats, so it shows a moving pattern
  assign wire_lvl = chan_en_i ? chan_dout_i : enc_level_i;
  assign link_data_in_o = (on && sel_i.clk_not_open) ? wire_lvl : idle_pat;
  assign open_proto_data_in_o = (on && !sel_i.clk_not_open) ? enc_level_i : idle_pat;
  assign led_o = on ? {sel_i.link_select, sel_i.clk_not_open} : 2'h0;
  assign supply_o = !on ? 3'h0 : sel_i.link_select ? 3'h4 : sel_i.clk_not_open ? 3'h2 : 3'h1;
endmodule : eps_far_side
`default_nettype wire

// File: testbench/tb_encoder_protocol_autoselect.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_encoder_protocol_autoselect;
  import eps_pkg::*;
  typedef struct {logic we; logic [11:0] adr; logic [31:0] wd; logic [31:0] msk; logic [31:0] ex;} eps_row_t;
  localparam int BD = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pos_valid_i = 1'b0, pos_strobe_i = 1'b0;
  logic ch2 = 1'b0, enc_level = 1'b0, feed = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, pos_data_i = 32'h0, eng_out = 32'h0, rd;
  logic [31:0] wb_dat_o, eng_in;
  logic wb_ack_o, engine_run_o, chan_clk, chan_dout, chan_en, link_in, open_in, open_clk, tx;
  logic [2:0] supply;
  logic [7:0] b;
  eps_sel_t sel_o;
  eps_proto_t engine_proto_o;
  int n_errors = 0, checks_done = 0, fcnt = 0;
  eps_proto_t exp_pr[4] = '{PR_LINK, PR_OPEN, PR_CLOCK, PR_LINK};
  logic [6:0] exp_sel[4] = '{7'h39, 7'h00, 7'h19, 7'h39};
  logic [2:0] exp_sup[4] = '{3'h4, 3'h1, 3'h2, 3'h4};
  logic [7:0] exp_b[4] = '{8'hA5, 8'hC3, 8'h0F, 8'h1E};
  eps_row_t rows[11] = '{
    '{0, OFS_CTRL, 0, 32'h3, 32'h1}, '{0, OFS_STAT, 0, 32'hF0, 32'h80},
    '{0, OFS_LINK_SEL, 0, 32'h7, 32'h7}, '{0, OFS_PROTO_SEL, 0, 32'h7, 32'h7},
    '{0, OFS_ADAPTER_MUX_DISABLE, 0, 32'h7, 32'h7}, '{0, OFS_SHARED, 0, 32'h7, 32'h5},
    '{0, OFS_DATA_IN, 0, 32'h7, 32'h6}, '{0, OFS_ENC_CLK, 0, 32'h7, 32'h5},
    '{1, OFS_LINK_SEL, 32'hA5A5_A5A0, 32'hFFFF_FFFF, 32'hA5A5_A5A7},
    '{1, OFS_PROTO_SEL, 32'h0000_0F08, 32'hFFFF_FFFF, 32'h0000_0F0F},
    '{1, 12'h100, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0}};

  eps_autoselect #(.STARTUP_CYCLES(20), .TRIAL_CYCLES(100), .STALE_CYCLES(50), .BAUD_DIV(BD))
  eps_autoselect_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sel_o(sel_o), .engine_run_o(engine_run_o),
    .engine_proto_o(engine_proto_o), .pos_valid_i(pos_valid_i), .pos_strobe_i(pos_strobe_i),
    .pos_data_i(pos_data_i), .eng_ch2_clk_i(ch2), .eng_ch2_dout_i(ch2), .eng_ch2_oe_i(ch2),
    .engine_output_register_i(eng_out), .engine_input_register_o(eng_in),
    .channel_two_clock_o(chan_clk), .link_data_out_o(chan_dout), .link_drive_enable_o(chan_en),
    .link_data_in_i(link_in), .open_proto_data_in_i(open_in), .open_proto_clock_o(open_clk),
    .console_tx_o(tx));

  eps_far_side eps_far_side_inst (.clk_i(clk_i), .sel_i(sel_o), .chan_dout_i(chan_dout),
    .chan_en_i(chan_en), .enc_level_i(enc_level), .link_data_in_o(link_in),
    .open_proto_data_in_o(open_in), .mux_output_enable_n_o(), .led_o(), .supply_o(supply));

  always #2 clk_i = ~clk_i;

  // engine stand-in: a new position every ten cycles while feeding
  always @(posedge clk_i) begin
    fcnt <= (fcnt == 9) ? 0 : fcnt + 1;
    pos_strobe_i <= feed && (fcnt == 0);
  end

  task end_of_test;
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    `CHK("bus ack", 1'b1, wb_ack_o)
    if (wb_ack_o !== 1'b1) end_of_test();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task wait_run(input logic lvl, input int lim);
    int n;
    n = 0;
    while (engine_run_o !== lvl && n <= lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("engine run", lvl, engine_run_o)
    if (engine_run_o !== lvl) end_of_test();
  endtask : wait_run

  task get_byte(output logic [7:0] v);
    int n;
    n = 0;
    while (tx !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (tx !== 1'b0) begin
      `CHK("console start", 1'b0, tx)
      end_of_test();
    end
    repeat (2) @(posedge clk_i);
    `CHK("console start bit", 1'b0, tx)
    for (int j = 0; j < 8; j++) begin
      repeat (BD) @(posedge clk_i);
      v[j] = tx;
    end
    repeat (BD) @(posedge clk_i);
    `CHK("console stop bit", 1'b1, tx)
  endtask : get_byte

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("select after reset", 7'h00, sel_o)
    `CHK("console idle", 1'b1, tx)
    wait_run(1'b1, 40);
    foreach (rows[k]) begin
      if (rows[k].we) wb(1'b1, rows[k].adr, rows[k].wd);
      wb(1'b0, rows[k].adr, 32'h0);
      `CHK("register read", rows[k].ex, rd & rows[k].msk)
    end
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        wait_run(1'b0, 300);
        wait_run(1'b1, 20);
      end
      `CHK("protocol", exp_pr[i], engine_proto_o)
      `CHK("select pins", exp_sel[i], sel_o)
      `CHK("encoder supply", exp_sup[i], supply)
      ch2 <= 1'b1;
      eng_out <= 32'h0000_0002;
      enc_level <= 1'b1;
      repeat (5) @(posedge clk_i);
      `CHK("channel two pins", {3{i != 1}}, {chan_clk, chan_dout, chan_en})
      `CHK("open clock", i == 1, open_clk)
      `CHK("engine inputs", {20'h0, i != 1, 10'h0, i == 1}, eng_in)
      wb(1'b0, OFS_SHARED, 32'h0);
      `CHK("shared pad mode", (i == 1) ? 3'h7 : 3'h5, rd[2:0])
      ch2 <= 1'b0;
      eng_out <= 32'h0;
      enc_level <= 1'b0;
    end
    pos_data_i <= 32'hA5C3_0F1E;
    pos_valid_i <= 1'b1;
    feed <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      get_byte(b);
      `CHK("console byte", exp_b[k], b)
    end
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK("locked status", 32'hC0, rd & 32'h1F0)
    `CHK("select held", 7'h39, sel_o)
    wb(1'b0, OFS_POS, 32'h0);
    `CHK("position", 32'hA5C3_0F1E, rd)
    feed <= 1'b0;
    wait_run(1'b0, 120);
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK("stale loss", 32'h100, rd & 32'h1F0)
    wb(1'b1, OFS_STAT, 32'h100);
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK("loss cleared", 32'h0, rd & 32'h100)
    wait_run(1'b1, 20);
    `CHK("retry protocol", PR_LINK, engine_proto_o)
    feed <= 1'b1;
    repeat (60) @(posedge clk_i);
    pos_valid_i <= 1'b0;
    wait_run(1'b0, 10);
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK("invalid loss", 32'h100, rd & 32'h100)
    wait_run(1'b1, 20);
    wb(1'b1, OFS_CTRL, 32'h0);
    wait_run(1'b0, 5);
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK("disabled status", 32'h0, rd & 32'h87)
    wb(1'b1, OFS_CTRL, 32'h3);
    wait_run(1'b1, 30);
    `CHK("restart protocol", PR_LINK, engine_proto_o)
    // mid-run reset with the sequencer disabled and the loss flag still set
    wb(1'b1, OFS_CTRL, 32'h0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("reset select", 7'h00, sel_o)
    `CHK("reset engine run", 1'b0, engine_run_o)
    `CHK("reset console", 1'b1, tx)
    wait_run(1'b1, 40);
    `CHK("reset protocol", PR_LINK, engine_proto_o)
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK("reset status", 32'h80, rd & 32'h1F0)
    end_of_test();
  end
endmodule : tb_encoder_protocol_autoselect
`default_nettype wire
